// >>> dv/bixt_properties.sv
// assertions on the device end of the interconnect test link
`timescale 1ns/1ps
`default_nettype none
module bixt_properties
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        cas_n,
	input wire logic        ras_n,
	input wire logic        cs_n,
	input wire logic        we_n,
	input wire logic        power_down_n,
	input wire logic [10:0] addr,
	input wire logic [2:0]  bank,
	input wire logic [3:0]  byte_mask,
	input wire logic        clk_t,
	input wire logic        clk_c,
	input wire logic [1:0]  cmd,
	input wire logic [31:0] dq_o,
	input wire logic [31:0] dq_oe,
	input wire logic [3:0]  dqs_o,
	input wire logic [3:0]  dqs_oe,
	input wire logic        interconnect_test_mode,
	input wire logic        test_permit
);
	logic m;
	logic en;
	// enable needs mode plus strobe, select and power-down levels
	assign m = interconnect_test_mode;
	assign en = m & ~cas_n & ~cs_n & power_down_n;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// entry and exit edges as the device samples them
	sequence s_entry;
		$fell(cas_n) && !cs_n && !power_down_n && test_permit && !m;
	endsequence
	sequence s_exit;
		m && $rose(cas_n);
	endsequence
	a_data_enable: assert property (dq_oe == {32{en}})
		else $error("data enable mismatch");
	a_strobe_enable: assert property (dqs_oe == {4{en}})
		else $error("strobe enable mismatch");
	a_low_data_map: assert property (m |-> dq_o[10:0] == ~({11{ras_n}} ^ addr))
		else $error("data 0 to 10 wrong");
	a_mid_data_map: assert property (m |-> dq_o[20:11] == ~({10{ras_n}}
		^ {we_n, clk_c, clk_t, byte_mask, bank[2], bank[0], bank[1]}))
		else $error("data 11 to 20 wrong");
	a_high_data_map: assert property (m |-> dq_o[31:21]
		== ~({11{addr[0]}} ^ {bank[0], addr[10:1]}))
		else $error("data 21 to 31 wrong");
	a_strobe_map: assert property (m |-> dqs_o
		== ~({4{addr[0]}} ^ {byte_mask[1:0], bank[2], bank[1]}))
		else $error("strobe values wrong");
	a_entry_taken: assert property (s_entry |=> m)
		else $error("entry edge ignored");
	a_exit_taken: assert property (s_exit |=> !m && !test_permit)
		else $error("exit edge ignored");
	a_no_reentry: assert property (!test_permit && !m |=> !m)
		else $error("mode entered without permit");
	a_close_ends_mode: assert property (cmd inside {2'h1, 2'h2}
		|=> !m && !test_permit)
		else $error("page close kept mode");
	a_no_close_live: assert property (m
		|-> !(cmd inside {2'h1, 2'h2}))
		else $error("page close during test mode");
	a_exit_disabled: assert property (s_exit
		|-> cs_n || !power_down_n)
		else $error("exit with outputs enabled");
endmodule // bixt_properties
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench: controller and device joined over the test link
`timescale 1ns/1ps
`default_nettype none
`include "bixt_params.svh"
module testbench;
	localparam logic [18:0] FP = 19'h2AAAA;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] rdat;
	logic        rerr;
	logic        mode;
	logic        permit;
	logic        fmode;
	logic        seen;
	logic [18:0] pats [5];
	int          miscompares;
	int          num_checks;
	int          cyc;
	bixt_if lnk();
	bixt_if flt();
	// counts shortened so a full init sequence takes tens of cycles
	bixt_ctl #(.PWR_CYC(4), .CLKW_CYC(4), .LOCK_CYC(4)) i_bixt_ctl (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pins(lnk));
	bixt_dev i_bixt_dev (.pclk(pclk), .presetn(presetn), .pins(lnk),
		.interconnect_test_mode(mode), .test_permit(permit));
	// second device faces the bench, which breaks the controller's rules
	bixt_dev i_bixt_dev_flt (.pclk(pclk), .presetn(presetn), .pins(flt),
		.interconnect_test_mode(fmode), .test_permit());
	bixt_properties i_bixt_properties (.pclk(pclk), .presetn(presetn),
		.cas_n(lnk.cas_n), .ras_n(lnk.ras_n), .cs_n(lnk.cs_n),
		.we_n(lnk.we_n), .power_down_n(lnk.power_down_n), .addr(lnk.addr),
		.bank(lnk.bank), .byte_mask(lnk.byte_mask), .clk_t(lnk.clk_t),
		.clk_c(lnk.clk_c), .cmd(lnk.cmd), .dq_o(lnk.dq_o),
		.dq_oe(lnk.dq_oe), .dqs_o(lnk.dqs_o), .dqs_oe(lnk.dqs_oe),
		.interconnect_test_mode(mode), .test_permit(permit));
	// clock
	initial
	begin
		pclk = 1'h0;
		forever #4 pclk = ~pclk;
	end
	// expected {strobes, data} for {row, addr, bank, mask}, others low
	function automatic logic [35:0] xv(input logic [18:0] p);
		logic        r;
		logic [10:0] a;
		logic [2:0]  b;
		logic [3:0]  k;
		{r, a, b, k} = p;
		return ~({{15{a[0]}}, {21{r}}} ^ {k[1:0], b[2], b[1], b[0], a[10:1],
			3'h0, k, b[2], b[0], b[1], a});
	endfunction
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [35:0] e,
		input logic [35:0] s);
		num_checks++;
		if (s !== e)
		begin
			$display("unexpected %s expected %h seen %h", n, e, s);
			miscompares++;
		end
	endtask
	task automatic rst();
		presetn <= 1'h0;
		seen <= 1'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
	endtask
	// one apb transfer; the request holds until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1)
			@(posedge pclk); // pready high or the hang guard ends a wait
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task automatic wait_done();
		rdat = 32'h0;
		repeat (100)
			if (rdat[3:0] !== bixt_pkg::BIXT_S_DONE)
				apb(1'h0, `BIXT_REG_STAT, 32'h0);
		chk("state", 36'h9, {32'h0, rdat[3:0]});
	endtask
	task automatic run_test(input logic [18:0] p);
		rst();
		apb(1'h1, `BIXT_REG_PAT, {13'h0, p});
		apb(1'h0, `BIXT_REG_PAT, 32'h0);
		chk("pattern", {17'h0, p}, {17'h0, rdat[18:0]});
		apb(1'h1, `BIXT_REG_CTRL, 32'h1);
		wait_done();
		chk("entered", 36'h1, {35'h0, seen});
		chk("exit", 36'h0, {34'h0, mode, permit});
		apb(1'h0, `BIXT_REG_DATA, 32'h0);
		chk("data", {4'h0, 32'(xv(p))}, {4'h0, rdat});
		apb(1'h0, `BIXT_REG_STRB, 32'h0);
		chk("strobe", xv(p) >> 32, {32'h0, rdat[3:0]});
	endtask
	task automatic skip_test();
		rst();
		apb(1'h1, `BIXT_REG_CTRL, 32'h3);
		wait_done();
		chk("skip", 36'h0, {34'h0, seen, permit});
		apb(1'h0, 12'hFFC, 32'h0);
		chk("unmapped", 36'h1, {35'h0, rerr});
	endtask
	// bench drives {cas_n, cs_n, power_down_n, cmd} of the second link
	task automatic fs(input logic [4:0] v);
		{flt.cas_n, flt.cs_n, flt.power_down_n, flt.cmd} <= v;
		repeat (2) @(posedge pclk);
	endtask
	task automatic fault_test();
		rst();
		fs(5'h0);
		chk("entry", 36'h1, {35'h0, fmode});
		fs(5'h4);
		chk("drive", xv(FP), {flt.dqs_o, flt.dq_o});
		chk("enable", 36'hFFFFFFFFF, {flt.dqs_oe, flt.dq_oe});
		fs(5'hC);
		chk("disable", 36'h0, {flt.dqs_oe, flt.dq_oe});
		fs(5'hE);
		chk("closed", 36'h0, {35'h0, fmode});
		fs(5'h10);
		fs(5'h0);
		chk("reentry", 36'h0, {35'h0, fmode});
	endtask
	// entry monitor and hang guard
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (mode === 1'h1)
			seen <= 1'h1;
		if (cyc == 20000)
		begin
			miscompares++;
			complete_run();
		end
	end
	initial
	begin
		pats = '{19'h00000, 19'h7FFFF, 19'h2AAAA, 19'h55555, 19'h00801};
		miscompares = 0;
		num_checks = 0;
		cyc = 0;
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		{flt.cas_n, flt.cs_n, flt.power_down_n, flt.cmd} = 5'h10;
		{flt.we_n, flt.clk_t, flt.clk_c} = 3'h0;
		{flt.ras_n, flt.addr, flt.bank, flt.byte_mask} = FP;
		@(posedge pclk);
		foreach (pats[i])
			run_test(pats[i]);
		skip_test();
		fault_test();
		complete_run();
	end
endmodule // testbench
`default_nettype wire

// >>> rtl/bixt_ctl.sv
// controller end: apb-driven test sequence and power-on init
`timescale 1ns/1ps
`default_nettype none
`include "bixt_params.svh"
module bixt_ctl
#(
	parameter int PWR_CYC  = `BIXT_PWR_CYC,
	parameter int CLKW_CYC = `BIXT_CLKW_CYC,
	parameter int LOCK_CYC = `BIXT_LOCK_CYC
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	bixt_if.ctl              pins
);
	// counters load these values; a count below one is flagged as an error at elaboration
	if (PWR_CYC < 1 || CLKW_CYC < 1 || LOCK_CYC < 1)
	begin : g_bad_counts
		$error("bixt_ctl: counts must be at least one");
	end

	bixt_pkg::bixt_state_t st, next_st;
	logic [31:0] cnt, next_cnt;
	logic [18:0] pat, next_pat;
	logic [31:0] cap_dq, next_cap_dq;
	logic [3:0]  cap_dqs, next_cap_dqs;
	logic [31:0] next_prdata;
	logic        next_pslverr;
	logic        start, skip;
	logic        cas_n, cs_n, pd_n;
	logic [1:0]  cmd;
	logic        acc, wr;

	assign acc   = psel && penable;
	assign wr    = acc && pwrite && paddr == `BIXT_REG_CTRL;
	assign start = wr && pwdata[`BIXT_CTRL_START];
	assign skip  = pwdata[`BIXT_CTRL_SKIP];

	// sequencer and apb register next values
	always_comb
	begin
		next_st      = st;
		next_cnt     = (cnt == 32'h0) ? 32'h0 : cnt - 32'h1;
		next_pat     = pat;
		next_cap_dq  = cap_dq;
		next_cap_dqs = cap_dqs;
		next_prdata  = prdata;
		next_pslverr = 1'b0;
		if (acc && pwrite && paddr == `BIXT_REG_PAT)
			next_pat = pwdata[18:0];
		// answer built in setup so it stands together with pready
		if (psel && !penable && !pwrite)
		begin
			if (paddr == `BIXT_REG_STAT)
				next_prdata = {28'h0, st};
			else if (paddr == `BIXT_REG_PAT)
				next_prdata = {13'h0, pat};
			else if (paddr == `BIXT_REG_DATA)
				next_prdata = cap_dq;
			else if (paddr == `BIXT_REG_STRB)
				next_prdata = {28'h0, cap_dqs};
			else if (paddr == `BIXT_REG_CTRL)
				next_prdata = 32'h0;
			else
			begin
				next_prdata  = 32'h0;
				next_pslverr = 1'b1;
			end
		end
		else if (psel && !penable && paddr != `BIXT_REG_CTRL &&
			paddr != `BIXT_REG_PAT)
			next_pslverr = 1'b1;
		case (st)
			bixt_pkg::BIXT_S_IDLE:
				if (start)
				begin
					next_st  = bixt_pkg::BIXT_S_PWR;
					next_cnt = 32'(PWR_CYC);
					if (skip)
						next_st = bixt_pkg::BIXT_S_CLKW;
					if (skip)
						next_cnt = 32'(CLKW_CYC);
				end
			bixt_pkg::BIXT_S_PWR:
				if (cnt == 32'h0)
				begin
					next_st  = bixt_pkg::BIXT_S_ENTER;
					next_cnt = 32'(`BIXT_PAT_CYC);
				end
			bixt_pkg::BIXT_S_ENTER:
				if (cnt == 32'h0)
				begin
					next_st  = bixt_pkg::BIXT_S_PAT;
					next_cnt = 32'h2;
				end
			bixt_pkg::BIXT_S_PAT:
				if (cnt == 32'h0)
				begin
					next_cap_dq  = pins.dq_o;
					next_cap_dqs = pins.dqs_o;
					next_st      = bixt_pkg::BIXT_S_DIS;
				end
			bixt_pkg::BIXT_S_DIS:
				next_st = bixt_pkg::BIXT_S_EXIT;
			bixt_pkg::BIXT_S_EXIT:
			begin
				next_st  = bixt_pkg::BIXT_S_EWAIT;
				next_cnt = 32'(`BIXT_EXIT_CYC);
			end
			bixt_pkg::BIXT_S_EWAIT:
				if (cnt == 32'h0)
				begin
					next_st  = bixt_pkg::BIXT_S_CLKW;
					next_cnt = 32'(CLKW_CYC);
				end
			bixt_pkg::BIXT_S_CLKW:
				if (cnt == 32'h0)
					next_st = bixt_pkg::BIXT_S_PCA;
			bixt_pkg::BIXT_S_PCA:
				next_st = bixt_pkg::BIXT_S_EXT_MODE_SET_CMD;
			bixt_pkg::BIXT_S_EXT_MODE_SET_CMD:
				next_st = bixt_pkg::BIXT_S_MRS;
			bixt_pkg::BIXT_S_MRS:
			begin
				next_st  = bixt_pkg::BIXT_S_LOCK;
				next_cnt = 32'(LOCK_CYC);
			end
			bixt_pkg::BIXT_S_LOCK:
				if (cnt == 32'h0)
				begin
					next_st  = bixt_pkg::BIXT_S_REF;
					next_cnt = 32'(`BIXT_REFRESHES - 1);
				end
			bixt_pkg::BIXT_S_REF:
				if (cnt == 32'h0)
					next_st = bixt_pkg::BIXT_S_MRSF;
			bixt_pkg::BIXT_S_MRSF:
				next_st = bixt_pkg::BIXT_S_DONE;
			default:
				next_st = st;
		endcase
	end

	// pin levels per state; page close never while test mode is live
	always_comb
	begin
		cas_n = 1'b1;
		cs_n  = 1'b1;
		pd_n  = 1'b0;
		cmd   = bixt_pkg::BIXT_CMD_NOP;
		case (next_st)
			bixt_pkg::BIXT_S_ENTER:
			begin
				cas_n = 1'b0;
				cs_n  = 1'b0;
			end
			bixt_pkg::BIXT_S_PAT:
			begin
				cas_n = 1'b0;
				cs_n  = 1'b0;
				pd_n  = 1'b1;
			end
			bixt_pkg::BIXT_S_DIS:
				cas_n = 1'b0; // cs high turns outputs off
			bixt_pkg::BIXT_S_IDLE, bixt_pkg::BIXT_S_PWR,
			bixt_pkg::BIXT_S_EXIT, bixt_pkg::BIXT_S_EWAIT,
			bixt_pkg::BIXT_S_CLKW:
				pd_n = 1'b0;
			bixt_pkg::BIXT_S_PCA:
			begin
				pd_n = 1'b1;
				cmd  = bixt_pkg::BIXT_CMD_PCA;
			end
			default:
			begin
				pd_n = 1'b1;
				cmd  = bixt_pkg::BIXT_CMD_OTHER;
			end
		endcase
		if (next_st == bixt_pkg::BIXT_S_LOCK || next_st == bixt_pkg::BIXT_S_DONE)
			cmd = bixt_pkg::BIXT_CMD_NOP;
	end

	// registered pins and bus answer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st                <= bixt_pkg::BIXT_S_IDLE;
			cnt               <= 32'h0;
			pat               <= 19'h0;
			cap_dq            <= 32'h0;
			cap_dqs           <= 4'h0;
			prdata            <= 32'h0;
			pslverr           <= 1'b0;
			pready            <= 1'b0;
			pins.cas_n        <= 1'b1;
			pins.cs_n         <= 1'b1;
			pins.power_down_n <= 1'b0;
			pins.cmd          <= 2'h0;
			{pins.ras_n, pins.addr, pins.bank, pins.byte_mask,
				pins.clk_t, pins.clk_c, pins.we_n} <= 22'h0;
		end
		else
		begin
			st                <= next_st;
			cnt               <= next_cnt;
			pat               <= next_pat;
			cap_dq            <= next_cap_dq;
			cap_dqs           <= next_cap_dqs;
			prdata            <= next_prdata;
			pslverr           <= next_pslverr;
			pready            <= psel && !penable; // no wait states
			pins.cas_n        <= cas_n;
			pins.cs_n         <= cs_n;
			pins.power_down_n <= pd_n;
			pins.cmd          <= cmd;
			{pins.ras_n, pins.addr, pins.bank, pins.byte_mask,
				pins.clk_t, pins.clk_c, pins.we_n} <= {pat, 3'h0};
		end
	end
endmodule // bixt_ctl
`default_nettype wire

// >>> rtl/bixt_dev.sv
// device end: xnor test outputs with entry/exit tracking
`timescale 1ns/1ps
`default_nettype none
module bixt_dev
(
	input  wire logic pclk,
	input  wire logic presetn,
	bixt_if.dev       pins,
	output logic      interconnect_test_mode,
	output logic      test_permit
);
	logic cas_d;
	logic next_mode;
	logic next_permit;
	logic next_cas_d;
	logic [31:0] xq;
	logic [3:0]  xs;
	logic        oe;

	// pins modelled as sampled once per clock; the test path itself is static
	always_comb
	begin
		next_cas_d  = pins.cas_n;
		next_permit = test_permit;
		next_mode   = interconnect_test_mode;
		if (pins.cmd == bixt_pkg::BIXT_CMD_PC ||
			pins.cmd == bixt_pkg::BIXT_CMD_PCA)
		begin
			next_permit = 1'b0;
			next_mode   = 1'b0; // page close kills the mode
		end
		else if (!interconnect_test_mode && test_permit && cas_d &&
			!pins.cas_n && !pins.cs_n && !pins.power_down_n)
			next_mode = 1'b1;
		else if (interconnect_test_mode && !cas_d && pins.cas_n)
		begin
			next_mode   = 1'b0;
			next_permit = 1'b0; // one entry per power-up
		end
	end

	// cas_d resets high so a low pin at release counts as a fall
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cas_d                  <= 1'b1;
			test_permit            <= 1'b1;
			interconnect_test_mode <= 1'b0;
		end
		else
		begin
			cas_d                  <= next_cas_d;
			test_permit            <= next_permit;
			interconnect_test_mode <= next_mode;
		end
	end

	// static xnor map, no clock in the data path
	always_comb
	begin
		xq[10:0] = ~({11{pins.ras_n}} ^ pins.addr);
		xq[11] = ~(pins.ras_n ^ pins.bank[1]);
		xq[12] = ~(pins.ras_n ^ pins.bank[0]);
		xq[13] = ~(pins.ras_n ^ pins.bank[2]);
		xq[17:14] = ~({4{pins.ras_n}} ^ pins.byte_mask);
		xq[18] = ~(pins.ras_n ^ pins.clk_t);
		xq[19] = ~(pins.ras_n ^ pins.clk_c);
		xq[20] = ~(pins.ras_n ^ pins.we_n);
		xq[30:21] = ~({10{pins.addr[0]}} ^ pins.addr[10:1]);
		xq[31] = ~(pins.addr[0] ^ pins.bank[0]);
		xs[0] = ~(pins.addr[0] ^ pins.bank[1]);
		xs[1] = ~(pins.addr[0] ^ pins.bank[2]);
		xs[2] = ~(pins.addr[0] ^ pins.byte_mask[0]);
		xs[3] = ~(pins.addr[0] ^ pins.byte_mask[1]);
		oe = interconnect_test_mode && !pins.cas_n && !pins.cs_n &&
			pins.power_down_n;
	end

	// enables drop whenever the condition fails
	assign pins.dq_o   = xq;
	assign pins.dqs_o  = xs;
	assign pins.dq_oe  = {32{oe}};
	assign pins.dqs_oe = {4{oe}};
endmodule // bixt_dev
`default_nettype wire

// >>> rtl/bixt_if.sv
// pin bundle between memory device and test controller
`timescale 1ns/1ps
`default_nettype none
interface bixt_if;
	logic        cas_n;
	logic        ras_n;
	logic        cs_n;
	logic        we_n;
	logic        power_down_n;
	logic [10:0] addr;
	logic [2:0]  bank;
	logic [3:0]  byte_mask;
	logic        clk_t;
	logic        clk_c;
	logic [1:0]  cmd;
	logic [31:0] dq_o;
	logic [31:0] dq_oe;
	logic [3:0]  dqs_o;
	logic [3:0]  dqs_oe;
	modport dev (input cas_n, ras_n, cs_n, we_n, power_down_n, addr, bank,
		byte_mask, clk_t, clk_c, cmd, output dq_o, dq_oe, dqs_o, dqs_oe);
	modport ctl (output cas_n, ras_n, cs_n, we_n, power_down_n, addr, bank,
		byte_mask, clk_t, clk_c, cmd, input dq_o, dq_oe, dqs_o, dqs_oe);
endinterface
`default_nettype wire

// >>> rtl/bixt_params.svh
// constants and rule summary for the board interconnect xnor test block
// Function
// - entry only before first page close
// - enter on column strobe fall, cs/pd low
// - exit on first column strobe rise
// - controller disables outputs before exit
// - drive xnor values when enable condition met
// - outputs are static function of pins
// - data 0..10 are row xnor address
// - data 11..20 row xnor bank/mask/clk/we
// - data 21..31 address0 xnor address/bank0
// - strobes 0..3 address0 xnor bank/mask
// - outputs high impedance unless enabled
// - controller issues no page close during test
// - power-down low, wait 100 us first
// - wait 10 ns after entry
// - wait 10 ns after exit
// - test sequence is optional
// - 200 us stable clock, nop, power-down high (controller holds power-down low until the page close)
// - close pages, ext set, dll reset, lock
// - two refreshes and final mode set
`ifndef BIXT_PARAMS_SVH
`define BIXT_PARAMS_SVH
`define BIXT_CLK_NS          8
`define BIXT_PWR_WAIT_NS     100000
`define BIXT_PATTERN_WAIT_NS 10
`define BIXT_EXIT_WAIT_NS    10
`define BIXT_CLK_WAIT_NS     200000
`define BIXT_PWR_CYC   ((`BIXT_PWR_WAIT_NS + `BIXT_CLK_NS - 1) / `BIXT_CLK_NS)
`define BIXT_PAT_CYC   ((`BIXT_PATTERN_WAIT_NS + `BIXT_CLK_NS - 1) / `BIXT_CLK_NS)
`define BIXT_EXIT_CYC  ((`BIXT_EXIT_WAIT_NS + `BIXT_CLK_NS - 1) / `BIXT_CLK_NS)
`define BIXT_CLKW_CYC  ((`BIXT_CLK_WAIT_NS + `BIXT_CLK_NS - 1) / `BIXT_CLK_NS)
`define BIXT_LOCK_CYC  400
`define BIXT_REFRESHES 2
`define BIXT_REG_CTRL   12'h000
`define BIXT_REG_STAT   12'h004
`define BIXT_REG_PAT    12'h008
`define BIXT_REG_DATA   12'h00C
`define BIXT_REG_STRB   12'h010
`define BIXT_CTRL_START 0
`define BIXT_CTRL_SKIP  1
`endif

// >>> rtl/bixt_pkg.sv
// types shared by both ends of the interconnect test link
package bixt_pkg;
	typedef enum logic [1:0] {
		BIXT_CMD_NOP  = 2'h0,
		BIXT_CMD_PC   = 2'h1,
		BIXT_CMD_PCA  = 2'h2,
		BIXT_CMD_OTHER = 2'h3
	} bixt_cmd_t;
	typedef enum logic [3:0] {
		BIXT_S_IDLE   = 4'h0,
		BIXT_S_PWR    = 4'h1,
		BIXT_S_ENTER  = 4'h3,
		BIXT_S_PAT    = 4'h2,
		BIXT_S_DIS    = 4'h6,
		BIXT_S_EXIT   = 4'h7,
		BIXT_S_EWAIT  = 4'h5,
		BIXT_S_CLKW   = 4'h4,
		BIXT_S_PCA    = 4'hC,
		BIXT_S_EXT_MODE_SET_CMD   = 4'hD,
		BIXT_S_MRS    = 4'hF,
		BIXT_S_LOCK   = 4'hE,
		BIXT_S_REF    = 4'hA,
		BIXT_S_MRSF   = 4'hB,
		BIXT_S_DONE   = 4'h9
	} bixt_state_t;
endpackage
